// [common/insn_field_pkg.sv]
// Shared encodings, field layouts, offsets and reset values for the field decoder.
// Assumes a single 125 MHz clock domain and an Avalon-MM register master.
package insn_field_pkg;

  localparam int unsigned CLOCK_PERIOD_NS = 8;

  // Register word offsets (byte addresses)
  localparam logic [3:0] OFF_SIB = 4'h0;
  localparam logic [3:0] OFF_IMM = 4'h4;
  localparam logic [3:0] OFF_COND = 4'h8;
  localparam logic [3:0] OFF_SPEC = 4'hC;

  // Reset values
  localparam logic [7:0] SIB_RESET = 8'h00;
  localparam logic [31:0] IMM_RESET = 32'h0000_0000;
  localparam logic [3:0] COND_RESET = 4'h0;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [4:0] SPEC_RESET = 5'h00;

  // Field positions in the scale-index-base byte
  localparam int unsigned SIB_SCALE_LSB = 6;
  localparam int unsigned SIB_INDEX_LSB = 3;
  localparam logic [2:0] INDEX_NONE = 3'h4;
  localparam logic [1:0] SCALE_ONE = 2'h0;

  // Immediate control field positions
  localparam int unsigned IMM_SIGN_BIT = 8;
  localparam int unsigned IMM_NARROW_BIT = 9;
  localparam int unsigned IMM_DEST_LSB = 10;

  // Flag positions in the condition register
  localparam int unsigned FLAG_LSB = 4;

  // Condition test selectors (upper three bits of the condition field)
  localparam logic [2:0] TEST_OVERFLOW = 3'h0;
  localparam logic [2:0] TEST_BELOW = 3'h1;
  localparam logic [2:0] TEST_ZERO = 3'h2;
  localparam logic [2:0] TEST_BELOW_EQ = 3'h3;
  localparam logic [2:0] TEST_SIGN = 3'h4;
  localparam logic [2:0] TEST_PARITY = 3'h5;
  localparam logic [2:0] TEST_LESS = 3'h6;
  localparam logic [2:0] TEST_LESS_EQ = 3'h7;

  typedef enum logic [1:0] {
    DEST_8,
    DEST_16,
    DEST_32
  } dest_width_e;

  typedef enum logic [1:0] {
    GROUP_CONTROL,
    GROUP_DEBUG,
    GROUP_TEST,
    GROUP_NONE
  } reg_group_e;

  typedef struct packed {
    logic carry;
    logic parity;
    logic zero;
    logic sign;
    logic overflow;
    logic spare;
  } flags_s;

  // One-hot special register select
  typedef struct packed {
    logic control_reg_zero;
    logic control_reg_two;
    logic control_reg_three;
    logic debug_reg_zero;
    logic debug_reg_one;
    logic debug_reg_two;
    logic debug_reg_three;
    logic debug_reg_six;
    logic debug_reg_seven;
    logic test_reg_six;
    logic test_reg_seven;
  } spec_sel_s;

  localparam logic [2:0] SEL_000 = 3'h0;
  localparam logic [2:0] SEL_001 = 3'h1;
  localparam logic [2:0] SEL_010 = 3'h2;
  localparam logic [2:0] SEL_011 = 3'h3;
  localparam logic [2:0] SEL_110 = 3'h6;
  localparam logic [2:0] SEL_111 = 3'h7;

endpackage

// [design/insn_field_decoder.sv]
// Instruction field decoder with an Avalon-MM register face.
// Assumes a master on the same clock; writes and reads answer in one cycle while clk_en is high.
// Function
// [RULE1] Index code 100 adds no index register
// [RULE2] Sign bit acts only for 8-to-wide immediates
// [RULE3] Sign bit 1 extends, 0 leaves unchanged
// [RULE4] Condition low bit selects test or negation
// [RULE5] Codes 000x overflow, 001x below, 010x zero
// [RULE6] Code 0110 below-or-equal, 0111 above
// [RULE7] Codes 100x sign, 101x even parity
// [RULE8] Code 1100 less, 1101 greater-or-equal
// [RULE9] Code 1110 less-or-equal, 1111 greater
// [RULE10] Control selector: 000, 010, 011
// [RULE11] Debug selector: 000-011, 110, 111
// [RULE12] Test selector: 110, 111
// [RULE13] Software uses only defined selector codes
// [RULE14] Conditions derive from carry, parity, zero, sign, overflow
module insn_field_decoder (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  output logic index_used,
  output logic addr_undefined,
  output logic [31:0] imm_operand,
  output logic cond_true,
  output insn_field_pkg::spec_sel_s spec_sel,
  output logic spec_sel_valid
);

  logic [7:0] sib_reg, sib_next;
  logic [31:0] imm_reg, imm_next;
  logic [3:0] cond_reg, cond_next;
  insn_field_pkg::flags_s flags_reg, flags_next;
  logic [4:0] spec_reg, spec_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic index_used_reg, index_used_next;
  logic addr_undef_reg, addr_undef_next;
  logic [31:0] operand_reg, operand_next;
  logic cond_true_reg, cond_true_next;
  insn_field_pkg::spec_sel_s sel_reg, sel_next;
  logic sel_valid_reg, sel_valid_next;

  logic [2:0] sib_index;
  logic [1:0] sib_scale;
  logic [7:0] imm_byte;
  logic imm_sign_ext;
  logic imm_narrow;
  insn_field_pkg::dest_width_e imm_dest;

  // Byte-lane merge used by the SIB and immediate registers
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] lanes);
    logic [31:0] result;
    result = old_val;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        result[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // Flag evaluation of a three-bit test
  function automatic logic eval_test(input logic [2:0] test,
                                     input insn_field_pkg::flags_s f);
    logic r;
    r = 1'b0;
    case (test)
      insn_field_pkg::TEST_OVERFLOW: r = f.overflow; // RULE5
      insn_field_pkg::TEST_BELOW: r = f.carry; // RULE14
      insn_field_pkg::TEST_ZERO: r = f.zero; // RULE5
      insn_field_pkg::TEST_BELOW_EQ: r = f.carry | f.zero; // RULE6
      insn_field_pkg::TEST_SIGN: r = f.sign; // RULE7
      insn_field_pkg::TEST_PARITY: r = f.parity; // RULE7
      insn_field_pkg::TEST_LESS: r = f.sign ^ f.overflow; // RULE8
      insn_field_pkg::TEST_LESS_EQ: r = f.zero | (f.sign ^ f.overflow); // RULE9
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  assign sib_index = sib_reg[insn_field_pkg::SIB_INDEX_LSB +: 3];
  assign sib_scale = sib_reg[insn_field_pkg::SIB_SCALE_LSB +: 2];
  assign imm_byte = imm_reg[7:0];
  assign imm_sign_ext = imm_reg[insn_field_pkg::IMM_SIGN_BIT];
  assign imm_narrow = imm_reg[insn_field_pkg::IMM_NARROW_BIT];
  assign imm_dest = insn_field_pkg::dest_width_e'(imm_reg[insn_field_pkg::IMM_DEST_LSB +: 2]);

  // Register bus: one-cycle answer, waitrequest high until the ack cycle
  always_comb begin
    sib_next = sib_reg;
    imm_next = imm_reg;
    cond_next = cond_reg;
    flags_next = flags_reg;
    spec_next = spec_reg;
    rdata_next = rdata_reg;
    err_next = 1'b0;
    ack_next = 1'b0;
    if ((avs_read || avs_write) && !ack_reg) begin
      ack_next = 1'b1;
      case (avs_address)
        insn_field_pkg::OFF_SIB: begin
          if (avs_write) begin
            sib_next = 8'(merge_lanes({24'h000000, sib_reg}, avs_writedata, avs_byteenable));
          end
          rdata_next = {24'h000000, sib_reg};
        end
        insn_field_pkg::OFF_IMM: begin
          if (avs_write) begin
            imm_next = merge_lanes(imm_reg, avs_writedata, avs_byteenable);
          end
          rdata_next = imm_reg;
        end
        insn_field_pkg::OFF_COND: begin
          if (avs_write && avs_byteenable[0]) begin
            cond_next = avs_writedata[3:0];
            flags_next = insn_field_pkg::flags_s'(avs_writedata[insn_field_pkg::FLAG_LSB +: 6]);
          end
          rdata_next = {22'h0, flags_reg, cond_reg};
        end
        insn_field_pkg::OFF_SPEC: begin
          if (avs_write && avs_byteenable[0]) begin
            spec_next = avs_writedata[4:0];
          end
          rdata_next = {27'h0, spec_reg};
        end
        default: begin
          err_next = 1'b1;
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sib_reg <= insn_field_pkg::SIB_RESET;
      imm_reg <= insn_field_pkg::IMM_RESET;
      cond_reg <= insn_field_pkg::COND_RESET;
      flags_reg <= insn_field_pkg::FLAGS_RESET;
      spec_reg <= insn_field_pkg::SPEC_RESET;
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (clk_en) begin
      sib_reg <= sib_next;
      imm_reg <= imm_next;
      cond_reg <= cond_next;
      flags_reg <= flags_next;
      spec_reg <= spec_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata = rdata_reg;
  assign avs_response_err = err_reg;

  // Field decode, registered one cycle behind the stored fields
  always_comb begin
    // Scale with no index is left to software; only flagged, not trapped
    index_used_next = (sib_index != insn_field_pkg::INDEX_NONE); // RULE1
    addr_undef_next = !index_used_next && (sib_scale != insn_field_pkg::SCALE_ONE); // RULE1
    if (imm_narrow && imm_sign_ext && (imm_dest != insn_field_pkg::DEST_8)) begin // RULE2
      if (imm_dest == insn_field_pkg::DEST_16) begin
        operand_next = {16'h0000, {8{imm_byte[7]}}, imm_byte}; // RULE3
      end else begin
        operand_next = {{24{imm_byte[7]}}, imm_byte}; // RULE3
      end
    end else if (imm_narrow) begin
      operand_next = {24'h000000, imm_byte}; // RULE3
    end else begin
      operand_next = imm_reg; // RULE2
    end
    cond_true_next = eval_test(cond_reg[3:1], flags_reg) ^ cond_reg[0]; // RULE4
    sel_next = '0;
    sel_valid_next = 1'b1;
    // Undefined codes select nothing; software must avoid them
    case (insn_field_pkg::reg_group_e'(spec_reg[4:3]))
      insn_field_pkg::GROUP_CONTROL: begin
        case (spec_reg[2:0])
          insn_field_pkg::SEL_000: sel_next.control_reg_zero = 1'b1; // RULE10
          insn_field_pkg::SEL_010: sel_next.control_reg_two = 1'b1; // RULE10
          insn_field_pkg::SEL_011: sel_next.control_reg_three = 1'b1; // RULE10
          default: sel_valid_next = 1'b0; // RULE13
        endcase
      end
      insn_field_pkg::GROUP_DEBUG: begin
        case (spec_reg[2:0])
          insn_field_pkg::SEL_000: sel_next.debug_reg_zero = 1'b1; // RULE11
          insn_field_pkg::SEL_001: sel_next.debug_reg_one = 1'b1; // RULE11
          insn_field_pkg::SEL_010: sel_next.debug_reg_two = 1'b1; // RULE11
          insn_field_pkg::SEL_011: sel_next.debug_reg_three = 1'b1; // RULE11
          insn_field_pkg::SEL_110: sel_next.debug_reg_six = 1'b1; // RULE11
          insn_field_pkg::SEL_111: sel_next.debug_reg_seven = 1'b1; // RULE11
          default: sel_valid_next = 1'b0; // RULE13
        endcase
      end
      insn_field_pkg::GROUP_TEST: begin
        case (spec_reg[2:0])
          insn_field_pkg::SEL_110: sel_next.test_reg_six = 1'b1; // RULE12
          insn_field_pkg::SEL_111: sel_next.test_reg_seven = 1'b1; // RULE12
          default: sel_valid_next = 1'b0; // RULE13
        endcase
      end
      default: sel_valid_next = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      index_used_reg <= 1'b0;
      addr_undef_reg <= 1'b0;
      operand_reg <= 32'h0000_0000;
      cond_true_reg <= 1'b0;
      sel_reg <= '0;
      sel_valid_reg <= 1'b0;
    end else if (clk_en) begin
      index_used_reg <= index_used_next;
      addr_undef_reg <= addr_undef_next;
      operand_reg <= operand_next;
      cond_true_reg <= cond_true_next;
      sel_reg <= sel_next;
      sel_valid_reg <= sel_valid_next;
    end
  end

  assign index_used = index_used_reg;
  assign addr_undefined = addr_undef_reg;
  assign imm_operand = operand_reg;
  assign cond_true = cond_true_reg;
  assign spec_sel = sel_reg;
  assign spec_sel_valid = sel_valid_reg;

  // Checks, all one cycle behind the stored fields or the bus read
  sequence fields_settled;
    !srst && clk_en;
  endsequence

  no_index_a: assert property (@(posedge clock) disable iff (srst) // RULE1
    fields_settled ##1 ($past(sib_index) == 3'h4 && $past(clk_en)) |-> !index_used)
    else $error("index used with no-index code");
  undef_addr_a: assert property (@(posedge clock) disable iff (srst) // RULE1
    (clk_en && sib_index == 3'h4 && sib_scale != 2'h0) |=> (!clk_en || addr_undefined))
    else $error("undefined address not flagged");
  sign_noeffect_a: assert property (@(posedge clock) disable iff (srst) // RULE2
    (clk_en && !imm_narrow) |=> (!clk_en || imm_operand == $past(imm_reg)))
    else $error("sign bit changed wide immediate");
  sign_extend_a: assert property (@(posedge clock) disable iff (srst) // RULE3
    (clk_en && imm_narrow && imm_dest == insn_field_pkg::DEST_32 && imm_sign_ext)
    |=> (!clk_en || imm_operand == {{24{$past(imm_reg[7])}}, $past(imm_reg[7:0])}))
    else $error("8-bit immediate not sign-extended");
  negate_pair_a: assert property (@(posedge clock) disable iff (srst) // RULE4
    (clk_en && $stable(flags_reg) && cond_reg[3:1] == $past(cond_reg[3:1])
     && cond_reg[0] != $past(cond_reg[0]) && $past(clk_en)) |=> (!clk_en || $changed(cond_true)))
    else $error("negation bit did not invert result");
  below_eq_a: assert property (@(posedge clock) disable iff (srst) // RULE6
    (clk_en && cond_reg == 4'h6) |=> (!clk_en || cond_true == ($past(flags_reg.carry)
     | $past(flags_reg.zero))))
    else $error("below-or-equal test wrong");
  less_a: assert property (@(posedge clock) disable iff (srst) // RULE8
    (clk_en && cond_reg == 4'hC) |=> (!clk_en || cond_true == ($past(flags_reg.sign)
     ^ $past(flags_reg.overflow))))
    else $error("signed less-than test wrong");
  greater_a: assert property (@(posedge clock) disable iff (srst) // RULE9
    (clk_en && cond_reg == 4'hF) |=> (!clk_en || cond_true == !($past(flags_reg.zero)
     | ($past(flags_reg.sign) ^ $past(flags_reg.overflow)))))
    else $error("signed greater-than test wrong");
  overflow_a: assert property (@(posedge clock) disable iff (srst) // RULE5
    (clk_en && cond_reg == 4'h0) |=> (!clk_en || cond_true == $past(flags_reg.overflow)))
    else $error("overflow test wrong");
  parity_a: assert property (@(posedge clock) disable iff (srst) // RULE7
    (clk_en && cond_reg == 4'hA) |=> (!clk_en || cond_true == $past(flags_reg.parity)))
    else $error("parity test wrong");
  ctrl_sel_a: assert property (@(posedge clock) disable iff (srst) // RULE10
    (clk_en && spec_reg == 5'h02) |=> (!clk_en || (spec_sel.control_reg_two && spec_sel_valid)))
    else $error("control register two not selected");
  debug_sel_a: assert property (@(posedge clock) disable iff (srst) // RULE11
    (clk_en && spec_reg == 5'h0F) |=> (!clk_en || (spec_sel.debug_reg_seven && spec_sel_valid)))
    else $error("debug register seven not selected");
  test_sel_a: assert property (@(posedge clock) disable iff (srst) // RULE12
    (clk_en && spec_reg == 5'h16) |=> (!clk_en || (spec_sel.test_reg_six && spec_sel_valid)))
    else $error("test register six not selected");
  bus_answer_a: assert property (@(posedge clock) disable iff (srst)
    (clk_en && avs_read && avs_waitrequest) |=> (!clk_en || !avs_waitrequest))
    else $error("bus answer late");

endmodule

// [test/fetch_source.sv]
// Avalon-MM master standing in for the prefetch queue that feeds decoder fields.
// Assumes a decoder on the same clock that answers with waitrequest low.
module fetch_source (
  input wire logic clock,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic avs_response_err
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end

  // Entered just after a rising edge; bounded only by the bench watchdog
  task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] data,
      input logic [3:0] be, output logic [31:0] rdata, output logic err);
    avs_address <= addr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= data;
    avs_byteenable <= be;
    // Values read here are those the rising edge samples
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    err = avs_response_err;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Released data bus shows no stale value
    avs_writedata <= ~data;
    @(posedge clock);
  endtask
endmodule

// [test/insn_field_decoder_test.sv]
// Self-checking bench: table of field writes, then hand-written awkward cases.
// Assumes one wait cycle per access and decoded outputs one cycle after a write.
module insn_field_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] data;
    logic [1:0] kind;
    logic [31:0] exp;
  } row_s;
  logic clock, srst, clk_en, avs_read, avs_write, avs_waitrequest, avs_response_err;
  logic index_used, addr_undefined, cond_true, spec_sel_valid, got_err;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, imm_operand, got_rd;
  insn_field_pkg::spec_sel_s spec_sel;
  int fail_count, num_checks;
  logic [5:0] fl[7] = '{6'h20, 6'h08, 6'h04, 6'h02, 6'h06, 6'h10, 6'h00};
  row_s rows[23] = '{
    '{4'h0, 32'h20, 2'h0, 32'h0}, '{4'h0, 32'h60, 2'h0, 32'h1},
    '{4'h0, 32'hE0, 2'h0, 32'h1}, '{4'h0, 32'hC8, 2'h0, 32'h2},
    '{4'h4, 32'h780, 2'h1, 32'hFF80}, '{4'h4, 32'hB80, 2'h1, 32'hFFFFFF80},
    '{4'h4, 32'hB7F, 2'h1, 32'h7F}, '{4'h4, 32'hA80, 2'h1, 32'h80},
    '{4'h4, 32'h6FF, 2'h1, 32'hFF}, '{4'h4, 32'h380, 2'h1, 32'h80},
    '{4'hC, 32'h00, 2'h3, 32'hC00}, '{4'hC, 32'h02, 2'h3, 32'hA00},
    '{4'hC, 32'h03, 2'h3, 32'h900}, '{4'hC, 32'h01, 2'h3, 32'h000},
    '{4'hC, 32'h08, 2'h3, 32'h880}, '{4'hC, 32'h09, 2'h3, 32'h840},
    '{4'hC, 32'h0A, 2'h3, 32'h820}, '{4'hC, 32'h0B, 2'h3, 32'h810},
    '{4'hC, 32'h0E, 2'h3, 32'h808}, '{4'hC, 32'h0F, 2'h3, 32'h804},
    '{4'hC, 32'h16, 2'h3, 32'h802}, '{4'hC, 32'h17, 2'h3, 32'h801},
    '{4'h4, 32'h12345180, 2'h1, 32'h12345180}};

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  insn_field_decoder uut (.clock(clock), .srst(srst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .index_used(index_used),
    .addr_undefined(addr_undefined), .imm_operand(imm_operand), .cond_true(cond_true),
    .spec_sel(spec_sel), .spec_sel_valid(spec_sel_valid));

  fetch_source u_src (.clock(clock), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err));

  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Returns after the decoded outputs have settled
  task automatic put(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    u_src.access(1'b1, a, d, be, got_rd, got_err);
    @(negedge clock);
  endtask

  function automatic logic [31:0] observe(input logic [1:0] kind);
    case (kind)
      2'h0: return {30'h0, index_used, addr_undefined};
      2'h1: return imm_operand;
      2'h2: return {31'h0, cond_true};
      default: return {20'h0, spec_sel_valid, spec_sel};
    endcase
  endfunction

  // Flags {carry, parity, zero, sign, overflow, spare}
  function automatic logic ref_cond(input logic [3:0] code, input logic [5:0] f);
    logic r;
    case (code[3:1])
      3'h0: r = f[1];
      3'h1: r = f[5];
      3'h2: r = f[3];
      3'h3: r = f[5] | f[3];
      3'h4: r = f[2];
      3'h5: r = f[4];
      3'h6: r = f[2] ^ f[1];
      default: r = f[3] | (f[2] ^ f[1]);
    endcase
    return r ^ code[0];
  endfunction

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim;
  end

  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    fail_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clock);
    @(negedge clock);
    check(imm_operand, 32'h0, "imm in reset");
    check({31'h0, cond_true}, 32'h0, "cond in reset");
    check({31'h0, avs_waitrequest}, 32'h0, "idle wait");
    check(observe(2'h0), 32'h0, "sib in reset");
    check(observe(2'h3), 32'h0, "select in reset");
    @(posedge clock);
    srst <= 1'b0;
    foreach (rows[i]) begin
      put(rows[i].addr, rows[i].data, 4'hF);
      check(observe(rows[i].kind), rows[i].exp, "row");
    end
    for (int c = 0; c < 16; c++) begin
      foreach (fl[k]) begin
        put(4'h8, {22'h0, fl[k], c[3:0]}, 4'hF);
        check({31'h0, cond_true}, {31'h0, ref_cond(c[3:0], fl[k])}, "cond");
      end
    end
    // Same flags, only the negation bit flips
    put(4'h8, 32'h124, 4'hF);
    check({31'h0, cond_true}, 32'h0, "zero clear");
    // Readback, then an unmapped address
    put(4'h8, 32'h125, 4'hF);
    check({31'h0, cond_true}, 32'h1, "not zero");
    @(posedge clock);
    u_src.access(1'b0, 4'h8, 32'h0, 4'hF, got_rd, got_err);
    check(got_rd, 32'h125, "readback");
    check({31'h0, got_err}, 32'h0, "mapped err");
    u_src.access(1'b0, 4'h2, 32'h0, 4'hF, got_rd, got_err);
    check(got_rd, 32'h0, "unmapped data");
    check({31'h0, got_err}, 32'h1, "unmapped err");
    // Missing low lane must leave the condition untouched
    put(4'h8, 32'h004, 4'h2);
    check({31'h0, cond_true}, 32'h1, "lane refused");
    // Frozen clock enable holds the ack back
    @(posedge clock);
    clk_en <= 1'b0;
    fork
      u_src.access(1'b1, 4'h8, 32'h004, 4'hF, got_rd, got_err);
      begin
        repeat (3) @(negedge clock);
        check({31'h0, avs_waitrequest}, 32'h1, "frozen ack");
        @(posedge clock);
        clk_en <= 1'b1;
      end
    join
    @(negedge clock);
    check({31'h0, cond_true}, 32'h0, "after freeze");
    // Second reset in mid-run
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    check(imm_operand, 32'h0, "imm after reset");
    check({31'h0, cond_true}, 32'h0, "cond after reset");
    @(posedge clock);
    u_src.access(1'b0, 4'h8, 32'h0, 4'hF, got_rd, got_err);
    check(got_rd, 32'h0, "cond reg after reset");
    end_sim;
  end
endmodule
